//--- hw/configurable_io_port_regs.v
// Register and pin logic for seven byte-wide configurable I/O ports A to G.
//
// How it works
// - Peripheral mode bit 7 set turns Port F into a data bus buffer.
// - In peripheral mode Port F floats except during a selected peripheral write outside I/O space.
// - Port E pins may be taken over for programming outside normal operation.
// - Port registers are read and written by ordinary bus cycles in I/O space.
// - Register bit n governs pin n of its own port only.
// - Mode, direction and drive registers clear to zero at reset.
// - On Ports E, F, G mode bit 0 is I/O, 1 is latched address.
// - Direction bit 1 makes an output, 0 an input; input by default.
// - On A, B, C, F the driver is on for direction OR enable term.
// - Port D keeps only the four low direction bits.
// - Where open drain applies, drive bit 1 selects open drain, 0 push-pull.
// - Where slew applies, drive bit 1 selects fast slew, 0 slow.
// - Open drain on A, B, E, G and D low nibble; slew on C, F.
// - Reading input value returns the levels present on the pins.
// - Output value register drives enabled pins and reads back as stored.
// - Macrocell location reads macrocell outputs; writes load unmasked flip-flops.
// - Mask bit 1 blocks the bus from loading that macrocell; reset zero.
// - Input macrocells of A, B, C store pins, feed logic, read back.
// - Enable status reads 1 for an enabled driver, 0 for one that is off; an open-drain pin released high still reads 1.
// - Registers exist only on the ports that carry them; others read zero.
`timescale 1ns/1ps
`default_nettype none
`include "io_port_defs.vh"

module configurable_io_port_regs (
    input wire CLK,
    input wire RESET_N,
    input wire BUS_SEL,
    input wire [7:0] BUS_ADDR,
    input wire BUS_WR,
    input wire BUS_RD,
    input wire [7:0] BUS_WDATA,
    output reg [7:0] BUS_RDATA,
    input wire [55:0] PIN_IN,
    output wire [55:0] PIN_OUT,
    output wire [55:0] PIN_OE,
    output wire [15:0] FAST_SLEW,
    input wire [31:0] PLD_OE,
    input wire [7:0] LATCHED_ADDR,
    input wire JTAG_ENABLE,
    input wire PERIPH_SEL_A,
    input wire PERIPH_SEL_B,
    input wire [15:0] MC_PLD_D,
    input wire [15:0] MC_PLD_LOAD,
    output reg [15:0] MACROCELL_Q,
    input wire [2:0] INPUT_MC_CAPTURE,
    output reg [23:0] INPUT_MC_Q,
    output wire PERIPH_MODE
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers.

    // True when the access targets register kind k of port p.
    function hit;
        input [7:0] addr;
        input [3:0] k;
        input [3:0] p;
        begin
            hit = (addr[7:4] == k) && (addr[3:0] == p);
        end
    endfunction

    // Picks the byte of port p from a seven-port vector; absent ports read zero.
    function [7:0] byte_of;
        input [55:0] v;
        input [3:0] p;
        begin
            case (p)
                `PORT_A: byte_of = v[7:0];
                `PORT_B: byte_of = v[15:8];
                `PORT_C: byte_of = v[23:16];
                `PORT_D: byte_of = v[31:24];
                `PORT_E: byte_of = v[39:32];
                `PORT_F: byte_of = v[47:40];
                `PORT_G: byte_of = v[55:48];
                default: byte_of = `UNMAPPED_READ;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Bus strobes and asynchronous control inputs.

    wire wr_cycle;
    wire rd_cycle;
    wire periph_sel;
    wire periph_on;
    wire periph_write;
    reg jtag_meta_q;
    reg jtag_q;
    reg [7:0] periph_mode_q;

    assign wr_cycle = BUS_SEL & BUS_WR;
    assign rd_cycle = BUS_SEL & BUS_RD;
    assign periph_sel = PERIPH_SEL_A | PERIPH_SEL_B;
    assign periph_on = periph_mode_q[`PERIPH_ENABLE_BIT];
    assign PERIPH_MODE = periph_on;
    assign periph_write = periph_on & periph_sel & BUS_WR & ~BUS_SEL;

    // The programming enable comes from a pin, so it is brought in by two flops.
    always @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            jtag_meta_q <= 1'b0;
            jtag_q <= 1'b0;
        end
        else
        begin
            jtag_meta_q <= JTAG_ENABLE;
            jtag_q <= jtag_meta_q;
        end
    end

    // Peripheral mode register; only bit 7 has an effect on the pins.
    always @(posedge CLK)
    begin
        if (!RESET_N)
            periph_mode_q <= `CONFIG_RESET;
        else if (wr_cycle && hit(BUS_ADDR, `KIND_PERIPH_MODE, `PORT_A))
            periph_mode_q <= BUS_WDATA;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Seven port slices.

    wire [55:0] dir_all;
    wire [55:0] drv_all;
    wire [55:0] ctrl_all;
    wire [55:0] dout_all;
    wire [55:0] din_all;
    wire [55:0] en_all;
    wire [55:0] slew_all;

    genvar i;
    generate
        for (i = 0; i < 7; i = i + 1)
        begin : g_port
            localparam [3:0] IDX = i;
            localparam [7:0] MASK = (i == 3) ? `PORT_D_PINS : `ALL_PINS;
            // mode bit on E, F, G
            localparam [0:0] CTRL = (i >= 4) ? 1'b1 : 1'b0;
            localparam [0:0] OE_TERM = (i < 3 || i == 5) ? 1'b1 : 1'b0;
            localparam [0:0] OD = (i == 2 || i == 5) ? 1'b0 : 1'b1;
            wire [7:0] pld_oe;
            wire ovr_en;
            wire [7:0] ovr_oe;
            wire [7:0] ovr_val;

            if (i < 3)
            begin : g_oe_low
                assign pld_oe = PLD_OE[8 * i +: 8];
            end
            else if (i == 5)
            begin : g_oe_f
                assign pld_oe = PLD_OE[31:24];
            end
            else
            begin : g_oe_none
                assign pld_oe = 8'h00;
            end

            if (i == 4)
            begin : g_jtag
                assign ovr_en = jtag_q;
                assign ovr_oe = 8'h00;
                assign ovr_val = 8'h00;
            end
            else if (i == 5)
            begin : g_periph
                assign ovr_en = periph_on;
                assign ovr_oe = {8{periph_write}};
                assign ovr_val = BUS_WDATA;
            end
            else
            begin : g_plain
                assign ovr_en = 1'b0;
                assign ovr_oe = 8'h00;
                assign ovr_val = 8'h00;
            end

            port_slice #(
                .PIN_MASK(MASK),
                .HAS_CTRL(CTRL),
                .HAS_OE_TERM(OE_TERM),
                .OPEN_DRAIN(OD)
            ) u_slice (
                .clk(CLK),
                .reset_n(RESET_N),
                .wr_dir(wr_cycle & hit(BUS_ADDR, `KIND_DIRECTION, IDX)),
                .wr_drv(wr_cycle & hit(BUS_ADDR, `KIND_DRIVE_SELECT, IDX)),
                .wr_ctrl(wr_cycle & hit(BUS_ADDR, `KIND_MODE_CONTROL, IDX)),
                .wr_dout(wr_cycle & hit(BUS_ADDR, `KIND_OUTPUT_VALUE, IDX)),
                .wdata(BUS_WDATA),
                .pin_in(PIN_IN[8 * i +: 8]),
                .pld_oe(pld_oe),
                .addr_out(LATCHED_ADDR),
                .ovr_en(ovr_en),
                .ovr_oe(ovr_oe),
                .ovr_val(ovr_val),
                .dir_q(dir_all[8 * i +: 8]),
                .drv_q(drv_all[8 * i +: 8]),
                .ctrl_q(ctrl_all[8 * i +: 8]),
                .dout_q(dout_all[8 * i +: 8]),
                .din_q(din_all[8 * i +: 8]),
                .en(en_all[8 * i +: 8]),
                .pin_out(PIN_OUT[8 * i +: 8]),
                .pin_oe(PIN_OE[8 * i +: 8]),
                .slew_fast(slew_all[8 * i +: 8])
            );
        end
    endgenerate

    assign FAST_SLEW = {slew_all[47:40], slew_all[23:16]};

    ////////////////////////////////////////////////////////////////////////////
    // Output macrocells of Ports A and B with load mask.

    reg [15:0] mask_q;
    wire [15:0] mc_bus_load;
    wire [15:0] mc_bus_data;

    // Mask register; a set bit shields the flip-flop from bus writes only.
    always @(posedge CLK)
    begin
        if (!RESET_N)
            mask_q <= `MASK_RESET;
        else if (wr_cycle && hit(BUS_ADDR, `KIND_LOAD_MASK, `PORT_A))
            mask_q[7:0] <= BUS_WDATA;
        else if (wr_cycle && hit(BUS_ADDR, `KIND_LOAD_MASK, `PORT_B))
            mask_q[15:8] <= BUS_WDATA;
    end

    assign mc_bus_load[7:0] = {8{wr_cycle & hit(BUS_ADDR, `KIND_MACROCELL, `PORT_A)}} & ~mask_q[7:0];
    assign mc_bus_load[15:8] = {8{wr_cycle & hit(BUS_ADDR, `KIND_MACROCELL, `PORT_B)}} & ~mask_q[15:8];
    assign mc_bus_data = {BUS_WDATA, BUS_WDATA};

    // load macrocell flip-flops
    // A bus load wins over the logic's own load in the same cycle, so the
    // value software just wrote is the one it reads back.
    always @(posedge CLK)
    begin
        if (!RESET_N)
            MACROCELL_Q <= 16'h0000;
        else
            MACROCELL_Q <= (mc_bus_load & mc_bus_data) | (~mc_bus_load & MC_PLD_LOAD & MC_PLD_D) |
                (~mc_bus_load & ~MC_PLD_LOAD & MACROCELL_Q);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input macrocells of Ports A, B and C.

    // store pin inputs
    // Captures the already synchronised pin levels, so no metastable bit
    // can reach the logic array.
    always @(posedge CLK)
    begin
        if (!RESET_N)
            INPUT_MC_Q <= 24'h000000;
        else
        begin
            if (INPUT_MC_CAPTURE[0])
                INPUT_MC_Q[7:0] <= din_all[7:0];
            if (INPUT_MC_CAPTURE[1])
                INPUT_MC_Q[15:8] <= din_all[15:8];
            if (INPUT_MC_CAPTURE[2])
                INPUT_MC_Q[23:16] <= din_all[23:16];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data path.

    reg [7:0] rd_d;
    reg [3:0] rd_port;

    always @*
    begin
        rd_port = BUS_ADDR[3:0];
        rd_d = `UNMAPPED_READ;
        case (BUS_ADDR[7:4])
            `KIND_INPUT_VALUE: rd_d = byte_of(din_all, rd_port);
            `KIND_OUTPUT_VALUE: rd_d = byte_of(dout_all, rd_port);
            `KIND_DIRECTION: rd_d = byte_of(dir_all, rd_port);
            `KIND_DRIVE_SELECT: rd_d = byte_of(drv_all, rd_port);
            `KIND_MODE_CONTROL: rd_d = byte_of(ctrl_all, rd_port);
            `KIND_ENABLE_STATUS:
            begin
                if (rd_port == `PORT_D || rd_port == `PORT_E || rd_port == `PORT_G)
                    rd_d = `UNMAPPED_READ;
                else
                    rd_d = byte_of(en_all, rd_port);
            end
            `KIND_MACROCELL:
            begin
                if (rd_port == `PORT_A || rd_port == `PORT_B)
                    rd_d = byte_of({40'h0000000000, MACROCELL_Q}, rd_port);
            end
            `KIND_LOAD_MASK:
            begin
                if (rd_port == `PORT_A || rd_port == `PORT_B)
                    rd_d = byte_of({40'h0000000000, mask_q}, rd_port);
            end
            `KIND_INPUT_MACROCELL:
            begin
                if (rd_port == `PORT_A || rd_port == `PORT_B || rd_port == `PORT_C)
                    rd_d = byte_of({32'h00000000, INPUT_MC_Q}, rd_port);
            end
            `KIND_PERIPH_MODE:
            begin
                if (rd_port == `PORT_A)
                    rd_d = periph_mode_q;
            end
            default: rd_d = `UNMAPPED_READ;
        endcase
    end

    // registered read data
    // A peripheral read outside I/O space returns Port F pins through the buffer.
    always @(posedge CLK)
    begin
        if (!RESET_N)
            BUS_RDATA <= `UNMAPPED_READ;
        else if (rd_cycle)
            BUS_RDATA <= rd_d;
        else if (BUS_RD && periph_on && periph_sel)
            BUS_RDATA <= din_all[47:40];
    end

endmodule

`default_nettype wire

//--- hw/io_port_defs.vh
// Constants for the configurable I/O port register block.
`ifndef IO_PORT_DEFS_VH
`define IO_PORT_DEFS_VH

// Register kind, carried in address bits 7:4 of the I/O register space.
`define KIND_INPUT_VALUE 4'h0
`define KIND_OUTPUT_VALUE 4'h1
`define KIND_DIRECTION 4'h2
`define KIND_DRIVE_SELECT 4'h3
`define KIND_MODE_CONTROL 4'h4
`define KIND_ENABLE_STATUS 4'h5
`define KIND_MACROCELL 4'h6
`define KIND_LOAD_MASK 4'h7
`define KIND_INPUT_MACROCELL 4'h8
`define KIND_PERIPH_MODE 4'h9

// Port index, carried in address bits 3:0.
`define PORT_A 4'h0
`define PORT_B 4'h1
`define PORT_C 4'h2
`define PORT_D 4'h3
`define PORT_E 4'h4
`define PORT_F 4'h5
`define PORT_G 4'h6

// Field positions and reset values.
`define PERIPH_ENABLE_BIT 7
`define CONFIG_RESET 8'h00
`define MASK_RESET 16'h0000
`define ALL_PINS 8'hff
`define PORT_D_PINS 8'h0f
`define UNMAPPED_READ 8'h00

`endif

//--- hw/port_slice.v
// One byte-wide port: configuration registers, pin sampling and pin driver.
`timescale 1ns/1ps
`default_nettype none

module port_slice #(
    parameter [7:0] PIN_MASK = 8'hff,
    parameter [0:0] HAS_CTRL = 1'b0,
    parameter [0:0] HAS_OE_TERM = 1'b0,
    parameter [0:0] OPEN_DRAIN = 1'b1
) (
    input wire clk,
    input wire reset_n,
    input wire wr_dir,
    input wire wr_drv,
    input wire wr_ctrl,
    input wire wr_dout,
    input wire [7:0] wdata,
    input wire [7:0] pin_in,
    input wire [7:0] pld_oe,
    input wire [7:0] addr_out,
    input wire ovr_en,
    input wire [7:0] ovr_oe,
    input wire [7:0] ovr_val,
    output reg [7:0] dir_q,
    output reg [7:0] drv_q,
    output reg [7:0] ctrl_q,
    output reg [7:0] dout_q,
    output reg [7:0] din_q,
    output wire [7:0] en,
    output wire [7:0] pin_out,
    output wire [7:0] pin_oe,
    output wire [7:0] slew_fast
);

    reg [7:0] meta_q;
    wire [7:0] en_raw;
    wire [7:0] val_raw;
    wire [7:0] val;
    wire [7:0] od;

    // Pins are asynchronous, so they pass two flops before anyone reads them.
    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            meta_q <= 8'h00;
            din_q <= 8'h00;
        end
        else
        begin
            meta_q <= pin_in;
            din_q <= meta_q & PIN_MASK;
        end
    end

    // Configuration registers; bits without a pin are never stored.
    // cleared at reset
    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            dir_q <= `CONFIG_RESET;
            drv_q <= `CONFIG_RESET;
            ctrl_q <= `CONFIG_RESET;
            dout_q <= `CONFIG_RESET;
        end
        else
        begin
            if (wr_dir)
                dir_q <= wdata & PIN_MASK;
            if (wr_drv)
                drv_q <= wdata & PIN_MASK;
            if (wr_ctrl && HAS_CTRL)
                ctrl_q <= wdata & PIN_MASK;
            if (wr_dout)
                dout_q <= wdata & PIN_MASK;
        end
    end

    // Driver on when the direction bit or the logic enable term is set.
    // direction sets output
    assign en_raw = (dir_q | (HAS_OE_TERM ? pld_oe : 8'h00)) & PIN_MASK;
    // Mode bit 1 sends the latched address, 0 sends the output register.
    assign val_raw = (ctrl_q & addr_out) | (~ctrl_q & dout_q);
    assign en = ovr_en ? (ovr_oe & PIN_MASK) : en_raw;
    assign val = ovr_en ? ovr_val : val_raw;
    // An open-drain pin only ever pulls low; a high is left to the pull-up.
    // open drain select
    assign od = OPEN_DRAIN ? drv_q : 8'h00;
    assign pin_oe = en & ~(od & val);
    assign pin_out = val & ~od & PIN_MASK;
    assign slew_fast = OPEN_DRAIN ? 8'h00 : drv_q;

endmodule

`default_nettype wire

//--- test/io_port_chk.sv
// Assertion checker for the configurable I/O port register block.
`timescale 1ns/1ps
`default_nettype none
module io_port_chk (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic BUS_SEL,
    input wire logic [7:0] BUS_ADDR,
    input wire logic BUS_WR,
    input wire logic BUS_RD,
    input wire logic [7:0] BUS_WDATA,
    input wire logic [7:0] BUS_RDATA,
    input wire logic [55:0] PIN_OUT,
    input wire logic [55:0] PIN_OE,
    input wire logic [15:0] FAST_SLEW,
    input wire logic [31:0] PLD_OE,
    input wire logic JTAG_ENABLE,
    input wire logic PERIPH_SEL_A,
    input wire logic PERIPH_SEL_B,
    input wire logic [15:0] MC_PLD_LOAD,
    input wire logic [15:0] MACROCELL_Q,
    input wire logic PERIPH_MODE
);
    wire wr = BUS_SEL && BUS_WR;
    wire pf_idle = PERIPH_MODE && !BUS_SEL && !PERIPH_SEL_A && !PERIPH_SEL_B;
    wire [7:0] mc_a = MACROCELL_Q[7:0];
    logic [7:0] mask_a_q;
    ////////////////////////////////////////
    // Shadow of the Port A load mask, because the mask itself never reaches a port.
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
            mask_a_q <= 8'h00;
        else if (wr && BUS_ADDR == 8'h70)
            mask_a_q <= BUS_WDATA;
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    reset_clear_a: assert property (
        $rose(RESET_N) |-> FAST_SLEW == 16'h0000 && MACROCELL_Q == 16'h0000 && !PERIPH_MODE)
        else $error("outputs not cleared by reset");
    slew_write_a: assert property (
        wr && BUS_ADDR == 8'h32 |=> FAST_SLEW[7:0] == $past(BUS_WDATA)) else $error("slew not updated");
    dir_or_en_a: assert property (
        wr && BUS_ADDR == 8'h22 |=> PIN_OE[23:16] == ($past(BUS_WDATA) | PLD_OE[23:16]))
        else $error("port c enable wrong");
    port_d_upper_a: assert property (
        PIN_OE[31:28] == 4'h0 && PIN_OUT[31:28] == 4'h0) else $error("port d upper pins driven");
    read_hold_a: assert property (
        !BUS_RD |=> $stable(BUS_RDATA)) else $error("read data moved without a read");
    unmapped_rd_a: assert property (
        BUS_SEL && BUS_RD && BUS_ADDR[3:0] > 4'h6 |=> BUS_RDATA == 8'h00) else $error("unmapped read not zero");
    periph_float_a: assert property (
        pf_idle |-> PIN_OE[47:40] == 8'h00) else $error("port f driven without select");
    periph_write_a: assert property (
        PERIPH_MODE && !BUS_SEL && (PERIPH_SEL_A || PERIPH_SEL_B) && BUS_WR
        |-> PIN_OE[47:40] == 8'hff && PIN_OUT[47:40] == BUS_WDATA) else $error("port f buffer wrong");
    mask_load_a: assert property (
        wr && BUS_ADDR == 8'h60 && MC_PLD_LOAD[7:0] == 8'h00 |=> ((mc_a ^ $past(BUS_WDATA)) & ~mask_a_q) == 8'h00
        && ((mc_a ^ $past(mc_a)) & mask_a_q) == 8'h00) else $error("macrocell mask not honoured");
    jtag_release_a: assert property (
        JTAG_ENABLE [*3] |-> PIN_OE[39:32] == 8'h00) else $error("port e still driven");
    cover property (wr && BUS_ADDR == 8'h60);
    cover property (PERIPH_MODE && PERIPH_SEL_A && BUS_WR);
    cover property (JTAG_ENABLE [*3]);
endmodule
bind configurable_io_port_regs io_port_chk chk_u (.CLK(CLK), .RESET_N(RESET_N), .BUS_SEL(BUS_SEL),
    .BUS_ADDR(BUS_ADDR), .BUS_WR(BUS_WR), .BUS_RD(BUS_RD), .BUS_WDATA(BUS_WDATA), .BUS_RDATA(BUS_RDATA),
    .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .FAST_SLEW(FAST_SLEW), .PLD_OE(PLD_OE), .JTAG_ENABLE(JTAG_ENABLE),
    .PERIPH_SEL_A(PERIPH_SEL_A), .PERIPH_SEL_B(PERIPH_SEL_B), .MC_PLD_LOAD(MC_PLD_LOAD),
    .MACROCELL_Q(MACROCELL_Q), .PERIPH_MODE(PERIPH_MODE));
`default_nettype wire

//--- test/pin_partner.sv
// Model of the board around the port pins: pull-ups plus an outside driver.
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
    input wire logic [55:0] pin_out,
    input wire logic [55:0] pin_oe,
    input wire logic [55:0] ext_val,
    input wire logic [55:0] ext_en,
    output logic [55:0] pin_in
);
    ////////////////////////////////////////
    // pull-ups, live levels
    // Device drivers win; a released line goes to its pull-up unless driven from outside.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ((ext_en & ext_val) | ~ext_en));
endmodule
`default_nettype wire

//--- test/test_configurable_io_port_regs.sv
// Self-checking testbench for the configurable I/O port register block.
`timescale 1ns/1ps
`default_nettype none
module test_configurable_io_port_regs;
    logic CLK, RESET_N, BUS_SEL, BUS_WR, BUS_RD, JTAG_ENABLE, PERIPH_SEL_A, PERIPH_SEL_B, PERIPH_MODE, rd_taken;
    logic [7:0] BUS_ADDR, BUS_WDATA, BUS_RDATA, LATCHED_ADDR, d, m, e, v;
    logic [55:0] PIN_IN, PIN_OUT, PIN_OE, ext_val, ext_en;
    logic [15:0] FAST_SLEW, MC_PLD_D, MC_PLD_LOAD, MACROCELL_Q;
    logic [31:0] PLD_OE;
    logic [2:0] INPUT_MC_CAPTURE;
    logic [23:0] INPUT_MC_Q;
    logic [7:0] exp_q[$];
    int bad_count, check_count;
    configurable_io_port_regs dut_u (.CLK(CLK), .RESET_N(RESET_N), .BUS_SEL(BUS_SEL), .BUS_ADDR(BUS_ADDR),
        .BUS_WR(BUS_WR), .BUS_RD(BUS_RD), .BUS_WDATA(BUS_WDATA), .BUS_RDATA(BUS_RDATA), .PIN_IN(PIN_IN),
        .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .FAST_SLEW(FAST_SLEW), .PLD_OE(PLD_OE), .LATCHED_ADDR(LATCHED_ADDR),
        .JTAG_ENABLE(JTAG_ENABLE), .PERIPH_SEL_A(PERIPH_SEL_A), .PERIPH_SEL_B(PERIPH_SEL_B), .MC_PLD_D(MC_PLD_D),
        .MC_PLD_LOAD(MC_PLD_LOAD), .MACROCELL_Q(MACROCELL_Q), .INPUT_MC_CAPTURE(INPUT_MC_CAPTURE),
        .INPUT_MC_Q(INPUT_MC_Q), .PERIPH_MODE(PERIPH_MODE));
    pin_partner far_u (.pin_out(PIN_OUT), .pin_oe(PIN_OE), .ext_val(ext_val), .ext_en(ext_en), .pin_in(PIN_IN));
    ////////////////////////////////////////
    // Free-running 100 MHz clock.
    initial
    begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    // Mismatches are reported at once; every comparison is counted.
    task automatic compare(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected %s at %0t: got %h expected %h", what, $time, got, exp);
        end
    endtask
    task automatic check_data(input logic [7:0] got, input logic [7:0] exp);
        compare(got, exp, "read data");
    endtask
    task automatic check_pins(input logic [7:0] got, input logic [7:0] exp);
        compare(got, exp, "pin lane");
    endtask
    // Strobes stay up across back-to-back cycles, so nothing is assigned twice in one step.
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] dt);
        BUS_SEL = 1'b1;
        BUS_WR = w;
        BUS_RD = !w;
        BUS_ADDR = a;
        BUS_WDATA = dt;
        @(negedge CLK);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        exp_q.push_back(exp);
        bus(1'b0, a, 8'h00);
    endtask
    task automatic idle(input int n);
        {BUS_SEL, BUS_WR, BUS_RD} = 3'h0;
        repeat (n) @(negedge CLK);
    endtask
    task automatic do_reset();
        RESET_N = 1'b0;
        repeat (12) @(negedge CLK);
        RESET_N = 1'b1;
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    ////////////////////////////////////////
    // Read data is registered on the read edge and checked half a cycle later; it is matched against the oldest note.
    always @(posedge CLK)
        rd_taken <= BUS_RD && RESET_N;
    always @(negedge CLK)
        if (rd_taken)
            check_data(BUS_RDATA, exp_q.pop_front());
    // The whole sequence needs well under a thousand cycles.
    initial
    begin
        #50000;
        bad_count++;
        stop_test();
    end
    initial
    begin
        {BUS_SEL, BUS_WR, BUS_RD, JTAG_ENABLE, PERIPH_SEL_A, PERIPH_SEL_B} = 6'h00;
        {BUS_ADDR, BUS_WDATA, LATCHED_ADDR, INPUT_MC_CAPTURE} = 27'h0;
        {MC_PLD_D, MC_PLD_LOAD, PLD_OE} = 64'h0;
        {ext_val, ext_en} = 112'h0;
        bad_count = 0;
        check_count = 0;
        d = $urandom(32'h0e02);
        do_reset();
        for (int p = 0; p < 7; p++)
            for (int k = 2; k < 5; k++)
                rd({k[3:0], p[3:0]}, 8'h00);
        rd(8'h70, 8'h00);
        // write, read back; refusals for absent registers and ports.
        for (int p = 0; p < 8; p++)
            for (int k = 1; k < 5; k++)
            begin
                d = $urandom;
                bus(1'b1, {k[3:0], p[3:0]}, d);
                rd({k[3:0], p[3:0]}, (p == 7 || (k == 4 && p < 4)) ? 8'h00 : (p == 3) ? (d & 8'h0f) : d);
            end
        rd(8'ha0, 8'h00);
        rd(8'h54, 8'h00);
        rd(8'h63, 8'h00);
        idle(1);
        do_reset();
        // Port C driver is direction OR enable term; released pins read the outside level.
        for (int i = 0; i < 4; i++)
        begin
            {d, m, e, v} = $urandom;
            ext_val[23:16] = v;
            ext_en[23:16] = 8'hff;
            bus(1'b1, 8'h12, d);
            bus(1'b1, 8'h22, m);
            PLD_OE[23:16] = e;
            idle(1);
            check_pins(PIN_OE[23:16], m | e);
            check_pins(PIN_OUT[23:16] & (m | e), d & (m | e));
            rd(8'h52, m | e);
            idle(2);
            rd(8'h02, (d & (m | e)) | (v & ~(m | e)));
        end
        // open drain on A, B, D, E, G; slew on C and F.
        for (int p = 0; p < 7; p++)
        begin
            {d, e} = $urandom;
            m = (p == 3) ? 8'h0f : 8'hff;
            bus(1'b1, {4'h1, p[3:0]}, d);
            bus(1'b1, {4'h2, p[3:0]}, 8'hff);
            bus(1'b1, {4'h3, p[3:0]}, e);
            idle(1);
            if (p == 2 || p == 5)
                check_pins(p == 5 ? FAST_SLEW[15:8] : FAST_SLEW[7:0], e);
            else
                check_pins(PIN_OE[p * 8 +: 8], m & ~(e & d));
            check_pins(PIN_OUT[p * 8 +: 8] & m & ~e, d & m & ~e);
        end
        // latched address on E, F, G
        LATCHED_ADDR = $urandom;
        for (int p = 4; p < 7; p++)
        begin
            bus(1'b1, {4'h3, p[3:0]}, 8'h00);
            bus(1'b1, {4'h4, p[3:0]}, 8'hff);
            idle(1);
            check_pins(PIN_OUT[p * 8 +: 8], LATCHED_ADDR);
        end
        // programming releases Port E; its registers keep their contents.
        JTAG_ENABLE = 1'b1;
        idle(3);
        check_pins(PIN_OE[39:32], 8'h00);
        JTAG_ENABLE = 1'b0;
        rd(8'h44, 8'hff);
        for (int p = 0; p < 2; p++)
        begin
            {m, d} = $urandom;
            bus(1'b1, {4'h7, p[3:0]}, m);
            bus(1'b1, {4'h6, p[3:0]}, d);
            rd({4'h6, p[3:0]}, d & ~m);
            rd({4'h7, p[3:0]}, m);
        end
        MC_PLD_D = $urandom;
        MC_PLD_LOAD = 16'h00ff;
        idle(1);
        MC_PLD_LOAD = 16'h0000;
        rd(8'h60, MC_PLD_D[7:0]);
        // Port B is released before its pins are used as inputs.
        v = $urandom;
        bus(1'b1, 8'h21, 8'h00);
        {ext_val[15:8], ext_en[15:8]} = {v, 8'hff};
        idle(3);
        INPUT_MC_CAPTURE = 3'h2;
        idle(1);
        INPUT_MC_CAPTURE = 3'h0;
        check_pins(INPUT_MC_Q[15:8], v);
        rd(8'h81, v);
        // Port F buffer opens only with a select term.
        {ext_val[47:40], ext_en[47:40]} = {~v, 8'hff};
        bus(1'b1, 8'h90, 8'h80);
        rd(8'h90, 8'h80);
        check_pins({7'h00, PERIPH_MODE}, 8'h01);
        idle(3);
        check_pins(PIN_OE[47:40], 8'h00);
        exp_q.push_back(~v);
        {PERIPH_SEL_B, BUS_RD} = 2'b11;
        @(negedge CLK);
        {PERIPH_SEL_A, PERIPH_SEL_B, BUS_RD, BUS_WR} = 4'b1001;
        BUS_WDATA = $urandom;
        #1;
        check_pins(PIN_OE[47:40], 8'hff);
        check_pins(PIN_OUT[47:40], BUS_WDATA);
        @(negedge CLK);
        {PERIPH_SEL_A, BUS_WR} = 2'b00;
        idle(2);
        stop_test();
    end
endmodule
`default_nettype wire
